// ===== dv/tct_pins_model.sv
/* far side pins: count pin, trigger pin and the other timer's overflow.
   assumes pull-ups, so released pins idle high. */
`default_nettype none
module tct_pins_model (
    // clock
    input wire logic clock,
    // pin drives
    output logic count_drive,
    output logic ext_trigger_pin,
    output logic other_timer_overflow
);
    timeunit 1ns;
    timeprecision 1ps;
    int tick = 0;
    initial
    begin
        count_drive = 1'b1;
        ext_trigger_pin = 1'b1;
        other_timer_overflow = 1'b0;
    end
    always @(posedge clock)
    begin
        tick <= (tick == 6) ? 0 : tick + 1;
        other_timer_overflow <= (tick == 6);
    end
    // each level held at least four clocks, above the synchroniser minimum
    task automatic fall(input bit trig);
        repeat (4) @(posedge clock);
        if (trig)
            ext_trigger_pin <= 1'b0;
        else
            count_drive <= 1'b0;
        repeat (4) @(posedge clock);
        if (trig)
            ext_trigger_pin <= 1'b1;
        else
            count_drive <= 1'b1;
        repeat (6) @(posedge clock);
    endtask
    task automatic set_trig(input logic lvl);
        @(posedge clock);
        ext_trigger_pin <= lvl;
        repeat (6) @(posedge clock);
    endtask
endmodule
`default_nettype wire

// ===== dv/tct_timer_monitor.sv
/* checker for the second timer/counter ports.
   assumes one clock and a bind onto tct_timer. */
`default_nettype none
module tct_timer_monitor (
    // clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // register port
    input wire tct_pkg::tct_req_t req,
    input wire logic [7:0] rdata,
    // pins and baud
    input wire logic count_clock_pin_out,
    input wire logic count_clock_pin_oe,
    input wire logic other_timer_overflow,
    input wire logic rx_baud_clock,
    input wire logic tx_baud_clock
);
    timeunit 1ns;
    timeprecision 1ps;
    import tct_pkg::*;
    // software-only control bits shadowed from writes
    logic [5:0] ctl_ff;
    logic [1:0] mod_ff;
    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            ctl_ff <= 6'h00;
            mod_ff <= 2'h0;
        end
        else if (req.wr && req.addr == ADDR_CONTROL)
            ctl_ff <= req.wdata[5:0];
        else if (req.wr && req.addr == ADDR_MODE_CONTROL)
            mod_ff <= req.wdata[1:0];
    end
    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);
    a_rdata_idle: assert property (!req.rd |=> rdata == 8'h00)
        else $error("read data not zero outside reply");
    a_ctl_read: assert property (req.rd && req.addr == ADDR_CONTROL |=> rdata[5:0] == ctl_ff)
        else $error("control readback wrong");
    a_mode_read: assert property (req.rd && req.addr == ADDR_MODE_CONTROL |=> rdata == {6'h00, mod_ff})
        else $error("mode readback wrong");
    a_unmapped_zero: assert property (req.rd && req.addr > ADDR_RELOAD_HIGH |=> rdata == 8'h00)
        else $error("unmapped read not zero");
    a_rx_other: assert property (!ctl_ff[5] && other_timer_overflow |=> rx_baud_clock)
        else $error("rx clock missed other timer pulse");
    a_tx_quiet: assert property (!ctl_ff[4] && !other_timer_overflow |=> !tx_baud_clock)
        else $error("tx clock pulse without source");
    a_oe_on: assert property ((mod_ff[1] && !ctl_ff[1]) [*2] |-> count_clock_pin_oe)
        else $error("pin not driven in clock-out");
    a_oe_off: assert property ((!mod_ff[1]) [*2] |-> !count_clock_pin_oe)
        else $error("pin driven without clock-out");
    a_pin_hold: assert property ((!mod_ff[1]) [*2] |=> $stable(count_clock_pin_out))
        else $error("pin toggled without clock-out");
endmodule
bind tct_timer tct_timer_monitor mon (.clock(clock), .sys_rst(sys_rst), .req(req),
    .rdata(rdata), .count_clock_pin_out(count_clock_pin_out),
    .count_clock_pin_oe(count_clock_pin_oe), .other_timer_overflow(other_timer_overflow),
    .rx_baud_clock(rx_baud_clock), .tx_baud_clock(tx_baud_clock));
`default_nettype wire

// ===== dv/tct_timer_test.sv
/* register-level tests of the second timer/counter.
   assumes the pins model drives the far side pins. */
`default_nettype none
module tct_timer_test;
    timeunit 1ns;
    timeprecision 1ps;
    import tct_pkg::*;
    localparam int RLD = 'hfffd;
    logic clock;
    logic sys_rst;
    tct_req_t req;
    logic [7:0] rdata;
    logic pin_out, pin_oe, pin_in, drive, trig, other, rx, tx, irq;
    int fail_count = 0;
    int total_checks = 0;
    int cycles = 0;
    int i, n, m;
    assign pin_in = pin_oe ? pin_out : drive;
    tct_pins_model pm (.clock(clock), .count_drive(drive), .ext_trigger_pin(trig),
        .other_timer_overflow(other));
    tct_timer uut (.clock(clock), .sys_rst(sys_rst), .req(req), .rdata(rdata),
        .count_clock_pin_in(pin_in), .count_clock_pin_out(pin_out),
        .count_clock_pin_oe(pin_oe), .ext_trigger_pin(trig),
        .other_timer_overflow(other), .rx_baud_clock(rx), .tx_baud_clock(tx),
        .timer_irq(irq));
    initial
    begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    task automatic final_report;
        $display("checks %0d failures %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            fail_count++;
            final_report();
        end
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("FAIL t=%0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clock);
        req <= '{a, d, 1'b1, 1'b0};
        @(posedge clock);
        req <= '0;
    endtask
    task automatic rd(input logic [2:0] a, input logic [7:0] exp);
        @(posedge clock);
        req <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge clock);
        req <= '0;
        #1;
        chk({8'h00, rdata}, {8'h00, exp});
    endtask
    task automatic wr16(input logic [2:0] a, input logic [15:0] v);
        wr(a, v[7:0]);
        wr(3'(a + 1), v[15:8]);
    endtask
    task automatic rd16(input logic [2:0] a, input logic [15:0] v);
        rd(a, v[7:0]);
        rd(3'(a + 1), v[15:8]);
    endtask
    // cycles between the second and third events on the pin or tx pulse
    task automatic ev_gap(input bit use_tx, output int g);
        logic p;
        int hits;
        p = pin_out;
        hits = 0;
        g = 0;
        while (hits < 3 && g < 200)
        begin
            @(posedge clock);
            #1;
            g++;
            if (use_tx ? tx === 1'b1 : pin_out !== p)
            begin
                hits++;
                if (hits < 3)
                    g = 0;
            end
            p = pin_out;
        end
    endtask
    initial
    begin
        sys_rst = 1'b1;
        req = '0;
        repeat (2) @(posedge clock);
        sys_rst <= 1'b0;
        for (i = 0; i < 8; i++)
            rd(3'(i), 8'h00);
        wr(3'h7, 8'hff);
        rd(3'h7, 8'h00);
        wr16(ADDR_COUNT_LOW, 16'h1234);
        repeat (40) @(posedge clock);
        rd16(ADDR_COUNT_LOW, 16'h1234);
        wr(ADDR_CONTROL, 8'h09);
        pm.fall(1'b1);
        rd16(ADDR_RELOAD_LOW, 16'h1234);
        rd(ADDR_CONTROL, 8'h49);
        chk({15'h0, irq}, 16'h0001);
        wr(ADDR_CONTROL, 8'h08);
        wr16(ADDR_COUNT_LOW, 16'h0000);
        pm.fall(1'b1);
        rd16(ADDR_COUNT_LOW, 16'h1234);
        rd(ADDR_CONTROL, 8'h48);
        wr(ADDR_CONTROL, 8'h28);
        wr16(ADDR_COUNT_LOW, 16'h0000);
        pm.fall(1'b1);
        rd16(ADDR_COUNT_LOW, 16'h0000);
        rd(ADDR_CONTROL, 8'h28);
        wr16(ADDR_RELOAD_LOW, 16'hfffe);
        wr16(ADDR_COUNT_LOW, 16'hfffe);
        wr(ADDR_CONTROL, 8'h04);
        for (i = 0; i < 100 && irq !== 1'b1; i++)
            @(posedge clock);
        rd(ADDR_CONTROL, 8'h84);
        wr(ADDR_CONTROL, 8'h80);
        rd(ADDR_CONTROL, 8'h80);
        rd16(ADDR_COUNT_LOW, 16'hfffe);
        wr(ADDR_CONTROL, 8'h00);
        rd(ADDR_CONTROL, 8'h00);
        chk({15'h0, irq}, 16'h0000);
        wr(ADDR_MODE_CONTROL, 8'hfd);
        rd(ADDR_MODE_CONTROL, 8'h01);
        wr16(ADDR_RELOAD_LOW, 16'h0010);
        wr16(ADDR_COUNT_LOW, 16'h0011);
        pm.set_trig(1'b0);
        wr(ADDR_CONTROL, 8'h06);
        pm.fall(1'b0);
        pm.fall(1'b0);
        rd16(ADDR_COUNT_LOW, 16'hffff);
        rd(ADDR_CONTROL, 8'hc6);
        pm.set_trig(1'b1);
        pm.fall(1'b0);
        rd16(ADDR_COUNT_LOW, 16'h0010);
        rd(ADDR_CONTROL, 8'h86);
        wr(ADDR_CONTROL, 8'h00);
        wr(ADDR_MODE_CONTROL, 8'h02);
        wr16(ADDR_RELOAD_LOW, RLD[15:0]);
        wr16(ADDR_COUNT_LOW, RLD[15:0]);
        wr(ADDR_CONTROL, 8'h04);
        ev_gap(1'b0, n);
        chk(16'(n), 16'(CLKOUT_DIVIDE * (65536 - RLD)));
        chk({15'h0, pin_oe}, 16'h0001);
        chk({15'h0, irq}, 16'h0000);
        wr(ADDR_CONTROL, 8'h34);
        wr(ADDR_CONTROL, 8'h34);
        ev_gap(1'b0, n);
        ev_gap(1'b1, m);
        chk(16'(m), 16'(n));
        rd(ADDR_CONTROL, 8'h34);
        for (i = 0; i < 100 && rx !== 1'b1; i++)
        begin
            @(posedge clock);
            #1;
        end
        chk({15'h0, rx}, 16'h0001);
        chk({15'h0, tx}, 16'h0001);
        final_report();
    end
endmodule
`default_nettype wire

// ===== rtl/tct_pkg.sv
/*
 * package for the second timer/counter: register offsets, bit positions,
 * reset values, mode encoding and timing constants.
 * assumes a 125 MHz system clock standing in for the oscillator.
 */
`default_nettype none
package tct_pkg;
    // register indices on the plain software port
    localparam logic [2:0] ADDR_CONTROL = 3'h0;
    localparam logic [2:0] ADDR_MODE_CONTROL = 3'h1;
    localparam logic [2:0] ADDR_COUNT_LOW = 3'h2;
    localparam logic [2:0] ADDR_COUNT_HIGH = 3'h3;
    localparam logic [2:0] ADDR_RELOAD_LOW = 3'h4;
    localparam logic [2:0] ADDR_RELOAD_HIGH = 3'h5;
    // control_reg bit positions
    localparam int CTL_OVERFLOW = 7;
    localparam int CTL_EXTERNAL = 6;
    localparam int CTL_RX_BAUD = 5;
    localparam int CTL_TX_BAUD = 4;
    localparam int CTL_EXT_EN = 3;
    localparam int CTL_RUN = 2;
    localparam int CTL_COUNTER = 1;
    localparam int CTL_CAPTURE = 0;
    // mode_control_reg bit positions
    localparam int MOD_CLK_OUT_EN = 1;
    localparam int MOD_DOWN_EN = 0;
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [7:0] MODE_CONTROL_RESET = 8'h00;
    localparam logic [7:0] MODE_CONTROL_MASK = 8'h03;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [15:0] COUNT_ZERO = 16'h0000;
    localparam logic [15:0] COUNT_FULL = 16'hffff;
    // prescale ratios of the oscillator
    localparam int TIMER_DIVIDE = 12;
    localparam int CLKOUT_DIVIDE = 2;
    localparam logic [3:0] PRESCALE_ZERO = 4'h0;
    typedef enum logic [3:0] {
        TCT_AUTO_RELOAD = 4'b0001,
        TCT_CAPTURE = 4'b0010,
        TCT_BAUD = 4'b0100,
        TCT_CLOCK_OUT = 4'b1000
    } tct_mode_t;
    // software port request
    typedef struct packed {
        logic [2:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } tct_req_t;
endpackage
`default_nettype wire

// ===== rtl/tct_timer.sv
/*
 * second timer/counter: 16-bit count with capture, auto-reload (up or
 * up/down), baud generator and clock-out modes, behind a plain register port.
 * assumes pins arrive asynchronously and that the baud pulses from the
 * other timer are on this clock.
 * a pin level must last at least one clock to be seen.
 * a software write to either count byte freezes the whole count for that
 * clock, so a running count may carry between two byte writes.
 * baud mode keeps the oscillator/12 step unless counter mode is chosen.
 * clock-out sets the overflow flag but never raises the interrupt.
 */
// Implementation choices: the address map and the address-and-strobe port.
`default_nettype none
// Overview of operation
// RULE_01 - count kept as two cascaded bytes, low byte carries into high byte
// RULE_02 - timer mode counts oscillator/12; counter mode counts pin falling edges
// RULE_03 - baud bits pick baud mode, else clock-out, capture, or auto-reload
// RULE_04 - auto-reload is the mode when no mode bits are set
// RULE_05 - capture mode counts freely and flags overflow on rollover
// RULE_06 - capture mode trigger falling edge copies count to reload, sets external flag
// RULE_07 - capture and up-only reload: both flags may raise interrupt
// RULE_08 - reset clears down-count enable, so reload mode counts up
// RULE_09 - up-only reload: overflow sets flag and loads reload value
// RULE_10 - up-only reload: trigger falling edge reloads and sets external flag
// RULE_11 - software presets reload value before relying on reloads
// RULE_12 - up/down with trigger high counts up, overflow flags and reloads
// RULE_13 - up/down with trigger low counts down, match flags and loads FFFF
// RULE_14 - up/down mode toggles external flag per wrap, no interrupt
// RULE_15 - clock-out steps at oscillator/2, reloads, raises no interrupt
// RULE_16 - clock-out enable makes overflows toggle a half-rate pin output
// RULE_17 - clock-out with timer select drives divided clock on pin
// RULE_18 - output frequency is oscillator over 4 times (65536 minus reload)
// RULE_19 - software loads reload, then count, then sets run
// RULE_20 - baud and clock-out may run together sharing the reload value
// RULE_21 - baud mode overflow pulses clock the serial port
// RULE_22 - overflow flag never set in baud mode; software clears it
// RULE_23 - baud mode forces reload on overflow, ignores trigger pin
// RULE_24 - rx and tx baud bits choose this or other timer pulses
// RULE_25 - counts only while run set; reload replaces the increment
module tct_timer #(
    parameter int TIMER_DIV = tct_pkg::TIMER_DIVIDE,
    parameter int CLKOUT_DIV = tct_pkg::CLKOUT_DIVIDE
) (
    // clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // register port
    input wire tct_pkg::tct_req_t req,
    output logic [7:0] rdata,
    // pins
    input wire logic count_clock_pin_in,
    output logic count_clock_pin_out,
    output logic count_clock_pin_oe,
    input wire logic ext_trigger_pin,
    // serial port baud clocks
    input wire logic other_timer_overflow,
    output logic rx_baud_clock,
    output logic tx_baud_clock,
    // interrupt request to the core
    output logic timer_irq
);
    import tct_pkg::*;

    logic [7:0] control_reg_ff;
    logic [7:0] mode_control_reg_ff;
    logic [7:0] count_low_ff;
    logic [7:0] count_high_ff;
    logic [7:0] reload_low_ff;
    logic [7:0] reload_high_ff;
    logic [7:0] rdata_ff;
    logic [3:0] prescale_ff;
    logic [2:0] t_pin_sync_ff;
    logic [2:0] x_pin_sync_ff;
    logic div2_ff;
    logic pin_out_ff;
    logic pin_oe_ff;
    logic rx_baud_ff;
    logic tx_baud_ff;
    logic irq_ff;

    tct_mode_t mode;
    logic baud_sel;
    logic run;
    logic down_mode;
    logic step;
    logic t_fall;
    logic x_fall;
    logic [15:0] count;
    logic [15:0] reload;
    logic [15:0] nxt_count;
    logic wrap;
    logic ext_event;
    logic capture_now;
    logic set_overflow;
    logic external_hit;
    logic external_toggle;
    logic count_up;
    logic reload_event;
    logic drive_pin;
    logic irq_source;
    logic [7:0] read_value;

    // high byte of a 16-bit value
    function automatic logic [7:0] hi_byte(input logic [15:0] v);
        hi_byte = v[15:8];
    endfunction

    // low byte of a 16-bit value
    function automatic logic [7:0] lo_byte(input logic [15:0] v);
        lo_byte = v[7:0];
    endfunction

    // software write strobe aimed at one register index
    function automatic logic wr_hit(input tct_req_t r, input logic [2:0] idx);
        wr_hit = r.wr && r.addr == idx;
    endfunction

    // prescaler at the last count of its divide ratio
    function automatic logic prescale_end(input logic [3:0] p, input logic [3:0] last);
        prescale_end = p == last;
    endfunction

    assign count = {count_high_ff, count_low_ff}; // RULE_01
    assign reload = {reload_high_ff, reload_low_ff};
    assign baud_sel = control_reg_ff[CTL_RX_BAUD] | control_reg_ff[CTL_TX_BAUD];
    assign run = control_reg_ff[CTL_RUN];
    assign down_mode = mode_control_reg_ff[MOD_DOWN_EN] && mode == TCT_AUTO_RELOAD;
    // up/down counts down only while the synchronised trigger level is low
    assign count_up = !down_mode || x_pin_sync_ff[1]; // RULE_12
    assign drive_pin = mode_control_reg_ff[MOD_CLK_OUT_EN]
        && !control_reg_ff[CTL_COUNTER]; // RULE_17

    // mode decode
    always_comb
    begin
        if (baud_sel) // RULE_03
            mode = TCT_BAUD;
        else if (mode_control_reg_ff[MOD_CLK_OUT_EN] && !control_reg_ff[CTL_CAPTURE])
            mode = TCT_CLOCK_OUT;
        else if (control_reg_ff[CTL_CAPTURE])
            mode = TCT_CAPTURE;
        else
            mode = TCT_AUTO_RELOAD; // RULE_04
    end

    // two-stage synchronisers plus one stage for edge detection
    // reset to the pull-up level so no false edge follows reset
    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            t_pin_sync_ff <= 3'h7;
            x_pin_sync_ff <= 3'h7;
        end
        else
        begin
            t_pin_sync_ff <= {t_pin_sync_ff[1:0], count_clock_pin_in};
            x_pin_sync_ff <= {x_pin_sync_ff[1:0], ext_trigger_pin};
        end
    end

    assign t_fall = t_pin_sync_ff[2] & ~t_pin_sync_ff[1];
    assign x_fall = x_pin_sync_ff[2] & ~x_pin_sync_ff[1];

    // oscillator prescaler: /12 for timer, /2 in clock-out
    always_ff @(posedge clock)
    begin
        if (sys_rst || !run)
            prescale_ff <= PRESCALE_ZERO;
        else if (mode == TCT_CLOCK_OUT && prescale_ff >= 4'(CLKOUT_DIV - 1)) // RULE_15
            prescale_ff <= PRESCALE_ZERO;
        else if (prescale_ff >= 4'(TIMER_DIV - 1))
            prescale_ff <= PRESCALE_ZERO;
        else
            prescale_ff <= prescale_ff + 4'h1;
    end

    always_comb
    begin
        if (!run) // RULE_25
            step = 1'b0;
        else if (mode == TCT_CLOCK_OUT) // RULE_17
            step = prescale_end(prescale_ff, 4'(CLKOUT_DIV - 1));
        else if (control_reg_ff[CTL_COUNTER]) // RULE_02
            step = t_fall;
        else
            step = prescale_end(prescale_ff, 4'(TIMER_DIV - 1));
    end

    // trigger pin falling edge only acts when enabled and not in baud mode
    assign ext_event = x_fall && control_reg_ff[CTL_EXT_EN] && !baud_sel; // RULE_23
    assign reload_event = ext_event && mode == TCT_AUTO_RELOAD && !down_mode; // RULE_10

    // next count, wrap detection and reload selection
    always_comb
    begin
        nxt_count = count + 16'h0001; // RULE_01
        wrap = 1'b0;
        // down-count: a match with the reload value underflows to all ones
        if (step && !count_up)
        begin
            if (count == reload) // RULE_13
            begin
                wrap = 1'b1;
                nxt_count = COUNT_FULL;
            end
            else
                nxt_count = count - 16'h0001;
        end
        // up-count: all ones overflows
        else if (step && count == COUNT_FULL)
        begin
            wrap = 1'b1;
            if (mode == TCT_CAPTURE) // RULE_05
                nxt_count = COUNT_ZERO;
            else
                nxt_count = reload; // RULE_09 RULE_12 RULE_15 RULE_23 RULE_25
        end
        else if (!step)
            nxt_count = count;
        if (reload_event) // RULE_10
            nxt_count = reload;
    end

    assign capture_now = ext_event && mode == TCT_CAPTURE; // RULE_06
    assign set_overflow = wrap && !baud_sel; // RULE_22
    assign external_hit = ext_event && !down_mode && mode != TCT_CLOCK_OUT;
    assign external_toggle = wrap && down_mode; // RULE_14

    // count halves: software write, else hardware step
    // a byte write wins over the hardware step in the same clock
    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            count_low_ff <= BYTE_ZERO;
            count_high_ff <= BYTE_ZERO;
        end
        else if (wr_hit(req, ADDR_COUNT_LOW))
            count_low_ff <= req.wdata;
        else if (wr_hit(req, ADDR_COUNT_HIGH))
            count_high_ff <= req.wdata;
        else
        begin
            count_low_ff <= lo_byte(nxt_count);
            count_high_ff <= hi_byte(nxt_count);
        end
    end

    // reload halves: software write or capture
    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            reload_low_ff <= BYTE_ZERO;
            reload_high_ff <= BYTE_ZERO;
        end
        else if (capture_now) // RULE_06
        begin
            reload_low_ff <= count_low_ff;
            reload_high_ff <= count_high_ff;
        end
        else if (wr_hit(req, ADDR_RELOAD_LOW)) // RULE_11
            reload_low_ff <= req.wdata;
        else if (wr_hit(req, ADDR_RELOAD_HIGH))
            reload_high_ff <= req.wdata;
    end

    // control register; hardware set wins over a software clear
    // up/down toggles the external flag from its old value
    always_ff @(posedge clock)
    begin
        if (sys_rst)
            control_reg_ff <= CONTROL_RESET;
        else
        begin
            if (wr_hit(req, ADDR_CONTROL))
                control_reg_ff <= req.wdata;
            if (set_overflow) // RULE_05 RULE_09 RULE_12 RULE_13
                control_reg_ff[CTL_OVERFLOW] <= 1'b1;
            if (external_hit) // RULE_06 RULE_10
                control_reg_ff[CTL_EXTERNAL] <= 1'b1;
            else if (external_toggle) // RULE_14
                control_reg_ff[CTL_EXTERNAL] <= ~control_reg_ff[CTL_EXTERNAL];
        end
    end

    // mode control keeps only its two defined bits
    always_ff @(posedge clock)
    begin
        if (sys_rst) // RULE_08
            mode_control_reg_ff <= MODE_CONTROL_RESET;
        else if (wr_hit(req, ADDR_MODE_CONTROL))
            mode_control_reg_ff <= req.wdata & MODE_CONTROL_MASK;
    end

    // divide-by-two stage and pin drive
    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            div2_ff <= 1'b0;
            pin_out_ff <= 1'b0;
            pin_oe_ff <= 1'b0;
        end
        else
        begin
            if (wrap && mode_control_reg_ff[MOD_CLK_OUT_EN]) // RULE_16 RULE_18 RULE_20
                div2_ff <= ~div2_ff;
            pin_out_ff <= div2_ff;
            pin_oe_ff <= drive_pin; // RULE_17
        end
    end

    // baud clock selection for the serial port
    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            rx_baud_ff <= 1'b0;
            tx_baud_ff <= 1'b0;
        end
        else
        begin
            rx_baud_ff <= control_reg_ff[CTL_RX_BAUD] ? wrap : other_timer_overflow; // RULE_21 RULE_24
            tx_baud_ff <= control_reg_ff[CTL_TX_BAUD] ? wrap : other_timer_overflow; // RULE_24
        end
    end

    // interrupt source: up/down drops the external flag, clock-out raises none
    always_comb
    begin
        if (mode == TCT_CLOCK_OUT) // RULE_15
            irq_source = 1'b0;
        else if (down_mode) // RULE_14
            irq_source = control_reg_ff[CTL_OVERFLOW]; // RULE_12
        else
            irq_source = control_reg_ff[CTL_OVERFLOW] | control_reg_ff[CTL_EXTERNAL]; // RULE_07
    end

    always_ff @(posedge clock)
    begin
        if (sys_rst)
            irq_ff <= 1'b0;
        else
            irq_ff <= irq_source;
    end

    // register selected by the read index; unmapped indices read zero
    always_comb
    begin
        case (req.addr)
            ADDR_CONTROL: read_value = control_reg_ff;
            ADDR_MODE_CONTROL: read_value = mode_control_reg_ff;
            ADDR_COUNT_LOW: read_value = count_low_ff;
            ADDR_COUNT_HIGH: read_value = count_high_ff;
            ADDR_RELOAD_LOW: read_value = reload_low_ff;
            ADDR_RELOAD_HIGH: read_value = reload_high_ff;
            default: read_value = BYTE_ZERO;
        endcase
    end

    // read data, one cycle after the strobe
    always_ff @(posedge clock)
    begin
        if (sys_rst || !req.rd)
            rdata_ff <= BYTE_ZERO;
        else
            rdata_ff <= read_value;
    end

    assign rdata = rdata_ff;
    assign count_clock_pin_out = pin_out_ff;
    assign count_clock_pin_oe = pin_oe_ff;
    assign rx_baud_clock = rx_baud_ff;
    assign tx_baud_clock = tx_baud_ff;
    assign timer_irq = irq_ff;
endmodule
`default_nettype wire
